// ==== verilog/sensor_scan_pkg.sv ====
package sensor_scan_pkg;

    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int NUM_INPUTS = 12;
    localparam int LANES      = 4;
    localparam int SCAN_CH    = 5;
    localparam int DATA_W     = 24;
    localparam int TIMER_W    = 26;

    // ---------------------------------------------------------------
    // Input indices: A, B, C1..C5, D1..D5
    // ---------------------------------------------------------------
    localparam logic [3:0] IDX_A    = 4'h0;
    localparam logic [3:0] IDX_B    = 4'h1;
    localparam logic [3:0] IDX_C1   = 4'h2;
    localparam logic [3:0] IDX_D1   = 4'h7;
    localparam logic [3:0] IDX_LAST = 4'hb;

    localparam int LANE_A = 0;
    localparam int LANE_B = 1;
    localparam int LANE_C = 2;
    localparam int LANE_D = 3;

    // ---------------------------------------------------------------
    // Ranges
    // ---------------------------------------------------------------
    localparam logic [3:0] RANGE_LOW       = 4'h0;
    localparam logic [3:0] RANGE_DIODE_TOP = 4'h1;
    localparam logic [3:0] RANGE_PTC_TOP   = 4'h6;
    localparam logic [3:0] RANGE_NTC_TOP   = 4'h8;
    localparam logic [3:0] RANGE_STEP      = 4'h1;
    localparam logic [3:0] EXC_NTC_BASE    = 4'h1;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int SLOT_TIME_MS     = 100;
    localparam int CLK_FREQ_HZ      = 100_000_000;
    localparam int MS_PER_S         = 1000;
    localparam int SLOT_CYCLES_DFLT = SLOT_TIME_MS * (CLK_FREQ_HZ / MS_PER_S);
    localparam int LONG_SLOT_FACTOR = 2;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        type_disabled,
        type_diode,
        positive_coefficient_resistor,
        negative_coefficient_resistor
    } sensor_type_t;

    typedef enum logic [3:0] {
        exc_off,
        exc_1ma,
        exc_300ua,
        exc_100ua,
        exc_30ua,
        exc_10ua,
        exc_3ua,
        exc_1ua,
        exc_300na,
        exc_100na
    } exc_t;

    typedef enum logic [2:0] {
        input_type_command,
        diode_current_command,
        range_command,
        autorange_command,
        reversal_command
    } cmd_op_t;

    typedef struct packed {
        sensor_type_t stype;
        logic         diode_high_current;
        logic [3:0]   range;
        logic         autorange;
        logic         reversal;
    } input_cfg_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] idx;
        cmd_op_t    op;
        logic [3:0] value;
    } cmd_t;

    typedef struct packed {
        logic       start;
        logic [3:0] input_idx;
        exc_t       exc;
        logic [3:0] range;
        logic       negative;
    } meas_req_t;

    typedef struct packed {
        logic                     done;
        logic                     over;
        logic                     under;
        logic signed [DATA_W-1:0] data;
    } adc_res_t;

    typedef struct packed {
        logic                     valid;
        logic [3:0]               input_idx;
        logic signed [DATA_W-1:0] value;
    } rdg_t;

    typedef struct packed {
        logic                     busy;
        logic [TIMER_W-1:0]       timer;
        logic                     negative;
        logic                     have_pos;
        logic signed [DATA_W-1:0] pos_value;
    } lane_t;

    typedef struct packed {
        input_cfg_t [NUM_INPUTS-1:0] cfg;
        lane_t      [LANES-1:0]      lane;
        meas_req_t  [LANES-1:0]      meas;
        rdg_t       [LANES-1:0]      rdg;
    } ctrl_state_t;

    typedef struct packed {
        logic [2:0] current;
    } seq_state_t;

endpackage : sensor_scan_pkg

// ==== verilog/scan_sequencer.sv ====
`timescale 1ns/10ps
module scan_sequencer
    import sensor_scan_pkg::*;
#(
    parameter int CHANNELS = SCAN_CH
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                ce,
    input  wire logic [CHANNELS-1:0] enable,
    input  wire logic                advance,
    output logic [2:0]               current,
    output logic [2:0]               enabled_count
);

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    if (CHANNELS < 1 || CHANNELS > SCAN_CH) begin : g_bad_channels
        $error("scan_sequencer: CHANNELS must be 1 to 5");
    end

    // ---------------------------------------------------------------
    // Channel order
    // ---------------------------------------------------------------
    function automatic logic [2:0] next_channel(input logic [CHANNELS-1:0] en,
                                                input logic [2:0]          cur);
        logic [2:0] first;
        logic [2:0] after;
        logic       found_first;
        logic       found_after;
        first       = 3'h0;
        after       = 3'h0;
        found_first = 1'b0;
        found_after = 1'b0;
        for (int i = 0; i < CHANNELS; i++) begin
            if (en[i] && !found_first) begin
                first       = 3'(i);
                found_first = 1'b1;
            end
            if (en[i] && !found_after && 3'(i) > cur) begin
                after       = 3'(i);
                found_after = 1'b1;
            end
        end
        return found_after ? after : first;
    endfunction : next_channel

    seq_state_t st;
    seq_state_t next_st;

    always_comb begin
        next_st = st;
        // A channel that was switched off under us is left at once
        if (advance || !enable[st.current]) begin
            next_st.current = next_channel(enable, st.current);
        end
    end

    always_comb begin
        enabled_count = 3'h0;
        for (int i = 0; i < CHANNELS; i++) begin
            enabled_count = enabled_count + 3'(enable[i]);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign current = st.current;

endmodule : scan_sequencer

// ==== verilog/sensor_input_scan_controller.sv ====
// Function
// - Setting type diode forces diode current to 10 uA; 1 mA only by later command.
// - Diode offers low 2.5 V and high 10 V range; low is default.
// - Positive-coefficient resistor always gets 1 mA on every range.
// - Negative-coefficient resistor current follows range, 1 mA at 10 ohm to 100 nA.
// - Autorange on negative-coefficient input keeps sensor voltage below 10 mV.
// - Manual range applies only with autorange off; otherwise range is automatic.
// - Setting either resistor type turns autorange on.
// - No autorange on diode inputs; diode range is explicit.
// - With reversal on, excitation polarity flips on alternate readings.
// - With reversal on, report half the difference of positive and negative reading; on shared C and D lanes the code pairs readings of successive channels.
// - Setting either resistor type turns reversal on; it may be turned off later.
// - Inputs C and D each scan up to five channels.
// - Every scanner channel keeps its own sensor type.
// - C and D sequencers run independently, timed by their own channels.
// - Each slot is 100 ms; N enabled channels update once per N slots.
// - Top negative-coefficient range takes 200 ms with other channels or reversal.
// - Types disabled/diode/resistors; diode default on A, B, C1, D1, else disabled.
`timescale 1ns/10ps
module sensor_input_scan_controller
    import sensor_scan_pkg::*;
#(
    parameter int SLOT_CYCLES = SLOT_CYCLES_DFLT
) (
    input  wire logic                         clk,
    input  wire logic                         nrst,
    input  wire logic                         ce,
    input  wire cmd_t                         cmd,
    input  wire adc_res_t   [LANES-1:0]       adc,
    output meas_req_t       [LANES-1:0]       meas,
    output rdg_t            [LANES-1:0]       rdg,
    output input_cfg_t      [NUM_INPUTS-1:0]  cfg_status
);

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // Long slot must fit the timer
    if (SLOT_CYCLES < 1 || SLOT_CYCLES * LONG_SLOT_FACTOR >= (1 << TIMER_W)) begin : g_bad_slot
        $error("sensor_input_scan_controller: SLOT_CYCLES out of timer range");
    end

    // Loads are one short: the timer stops at zero
    localparam logic [TIMER_W-1:0] SLOT_LAST = TIMER_W'(SLOT_CYCLES - 1);
    localparam logic [TIMER_W-1:0] LONG_LAST = TIMER_W'(SLOT_CYCLES * LONG_SLOT_FACTOR - 1);

    // ---------------------------------------------------------------
    // Reset state
    // ---------------------------------------------------------------
    function automatic ctrl_state_t reset_state();
        ctrl_state_t s;
        s = '0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            s.cfg[i].stype = type_disabled;
            s.cfg[i].range = RANGE_LOW;
        end

        s.cfg[IDX_A].stype  = type_diode;
        s.cfg[IDX_B].stype  = type_diode;
        s.cfg[IDX_C1].stype = type_diode;
        s.cfg[IDX_D1].stype = type_diode;

        for (int l = 0; l < LANES; l++) begin
            s.meas[l].exc = exc_off;
        end
        return s;
    endfunction : reset_state

    localparam ctrl_state_t RESET_STATE = reset_state();

    // ---------------------------------------------------------------
    // Excitation and range limits
    // ---------------------------------------------------------------
    function automatic exc_t excitation(input input_cfg_t c);
        exc_t e;
        case (c.stype)
            type_diode:                    e = c.diode_high_current ? exc_1ma : exc_10ua;
            positive_coefficient_resistor: e = exc_1ma;
            negative_coefficient_resistor: e = exc_t'(c.range + EXC_NTC_BASE);
            default:                       e = exc_off;
        endcase
        return e;
    endfunction : excitation

    function automatic logic [3:0] range_top(input sensor_type_t t);
        logic [3:0] r;
        case (t)
            type_diode:                    r = RANGE_DIODE_TOP;
            positive_coefficient_resistor: r = RANGE_PTC_TOP;
            negative_coefficient_resistor: r = RANGE_NTC_TOP;
            default:                       r = RANGE_LOW;
        endcase
        return r;
    endfunction : range_top

    function automatic logic is_resistor(input sensor_type_t t);
        return t == positive_coefficient_resistor || t == negative_coefficient_resistor;
    endfunction : is_resistor

    // ---------------------------------------------------------------
    // Scan sequencers for C and D
    // ---------------------------------------------------------------
    ctrl_state_t             st;
    ctrl_state_t             next_st;

    logic [SCAN_CH-1:0]      scan_en    [2];
    logic [2:0]              scan_cur   [2];
    logic [2:0]              scan_cnt   [2];
    logic [LANES-1:0]        advance;
    logic [3:0]              lane_in    [LANES];
    logic [LANES-1:0]        lane_shared;

    for (genvar s = 0; s < 2; s++) begin : g_scan
        localparam logic [3:0] BASE = (s == 0) ? IDX_C1 : IDX_D1;
        for (genvar c = 0; c < SCAN_CH; c++) begin : g_en
            assign scan_en[s][c] = st.cfg[BASE + 4'(c)].stype != type_disabled;
        end

        scan_sequencer #(
            .CHANNELS (SCAN_CH)
        ) u_seq (
            .clk           (clk),
            .nrst          (nrst),
            .ce            (ce),
            .enable        (scan_en[s]),
            .advance       (advance[LANE_C + s]),
            .current       (scan_cur[s]),
            .enabled_count (scan_cnt[s])
        );
    end

    always_comb begin
        lane_in[LANE_A]     = IDX_A;
        lane_in[LANE_B]     = IDX_B;
        lane_in[LANE_C]     = IDX_C1 + 4'(scan_cur[0]);
        lane_in[LANE_D]     = IDX_D1 + 4'(scan_cur[1]);

        lane_shared[LANE_A] = 1'b0;
        lane_shared[LANE_B] = 1'b0;
        lane_shared[LANE_C] = scan_cnt[0] > 3'h1;
        lane_shared[LANE_D] = scan_cnt[1] > 3'h1;

        for (int l = 0; l < LANES; l++) begin
            advance[l] = st.lane[l].busy && st.lane[l].timer == '0;
        end
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        input_cfg_t               c;
        logic [3:0]               cin;
        logic                     long_slot;
        logic                     stepped;
        logic signed [DATA_W:0]   diff;
        c         = '0;
        cin       = '0;
        long_slot = 1'b0;
        stepped   = 1'b0;
        diff      = '0;

        next_st   = st;

        // Configuration commands
        if (cmd.valid && cmd.idx <= IDX_LAST) begin
            c = st.cfg[cmd.idx];
            case (cmd.op)
                input_type_command: begin
                    c.stype = sensor_type_t'(cmd.value[1:0]);
                    if (c.stype == type_diode) begin
                        c.diode_high_current = 1'b0;
                        c.autorange          = 1'b0;
                        c.range              = RANGE_LOW;
                    end else if (is_resistor(c.stype)) begin
                        c.autorange = 1'b1;
                        c.reversal  = 1'b1;
                        c.range     = RANGE_LOW;
                    end
                end

                diode_current_command: begin
                    if (c.stype == type_diode) begin
                        c.diode_high_current = cmd.value[0];
                    end
                end

                range_command: begin
                    // Ignored while autoranging, and out-of-table codes are dropped
                    if (!c.autorange && cmd.value <= range_top(c.stype)) begin
                        c.range = cmd.value;
                    end
                end

                autorange_command: begin
                    c.autorange = cmd.value[0] && is_resistor(c.stype);
                end

                reversal_command: begin
                    c.reversal = cmd.value[0] && is_resistor(c.stype);
                end

                default: begin
                end
            endcase
            next_st.cfg[cmd.idx] = c;

            // A reconfigured input restarts its pair, unless a positive reading on its lane completes in the same cycle
            for (int l = 0; l < LANES; l++) begin
                if (lane_in[l] == cmd.idx) begin
                    next_st.lane[l].have_pos = 1'b0;
                    next_st.lane[l].negative = 1'b0;
                end
            end
        end

        // Measurement lanes
        for (int l = 0; l < LANES; l++) begin
            next_st.meas[l].start = 1'b0;
            next_st.rdg[l].valid  = 1'b0;

            cin = lane_in[l];
            c   = next_st.cfg[cin];

            if (!st.lane[l].busy) begin
                if (c.stype != type_disabled) begin
                    // Fixed for the whole slot
                    long_slot = c.stype == negative_coefficient_resistor
                             && c.range == RANGE_NTC_TOP
                             && (lane_shared[l] || c.reversal);
                    next_st.lane[l].busy     = 1'b1;
                    next_st.lane[l].timer    = long_slot ? LONG_LAST : SLOT_LAST;

                    next_st.meas[l].start     = 1'b1;
                    next_st.meas[l].input_idx = cin;
                    next_st.meas[l].exc       = excitation(c);
                    next_st.meas[l].range     = c.range;
                    next_st.meas[l].negative  = c.reversal && next_st.lane[l].negative;
                end
            end else begin
                if (adc[l].done) begin
                    stepped = 1'b0;

                    if (c.autorange && is_resistor(c.stype)) begin
                        // Over flags the sensor voltage at the 10 mV ceiling
                        if (adc[l].over && c.range < range_top(c.stype)) begin
                            c.range = c.range + RANGE_STEP;
                            stepped = 1'b1;
                        end else if (adc[l].under && c.range > RANGE_LOW) begin
                            c.range = c.range - RANGE_STEP;
                            stepped = 1'b1;
                        end
                    end

                    if (stepped) begin
                        // The reading was taken on the old range, so it is not reported
                        next_st.cfg[cin]         = c;
                        next_st.lane[l].have_pos = 1'b0;
                        next_st.lane[l].negative = 1'b0;
                    end else if (c.reversal) begin
                        if (!st.meas[l].negative) begin
                            next_st.lane[l].pos_value = adc[l].data;
                            next_st.lane[l].have_pos  = 1'b1;
                        end else if (next_st.lane[l].have_pos) begin
                            diff = {next_st.lane[l].pos_value[DATA_W-1],
                                    next_st.lane[l].pos_value}
                                 - {adc[l].data[DATA_W-1], adc[l].data};
                            next_st.rdg[l].valid     = 1'b1;
                            next_st.rdg[l].input_idx = cin;
                            next_st.rdg[l].value     = diff[DATA_W:1];
                            next_st.lane[l].have_pos = 1'b0;
                        end

                        next_st.lane[l].negative = !st.meas[l].negative;
                    end else begin
                        next_st.rdg[l].valid     = 1'b1;
                        next_st.rdg[l].input_idx = cin;
                        next_st.rdg[l].value     = adc[l].data;
                        next_st.lane[l].negative = 1'b0;
                    end
                end

                // Timer zero ends the slot
                if (advance[l]) begin
                    next_st.lane[l].busy = 1'b0;
                end else begin
                    next_st.lane[l].timer = st.lane[l].timer - TIMER_W'(1);
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= RESET_STATE;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Registered outputs
    assign meas       = st.meas;
    assign rdg        = st.rdg;
    assign cfg_status = st.cfg;

endmodule : sensor_input_scan_controller

// ==== dv/adc_front_end_model.sv ====
`timescale 1ns/10ps
module adc_front_end_model
    import sensor_scan_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire meas_req_t [LANES-1:0] meas,
    input  wire logic      [LANES-1:0] over,
    output adc_res_t       [LANES-1:0] adc
);
    int cnt [LANES];
    int mag;
    // Odd lanes answer late in the slot, even lanes almost at once
    always @(posedge clk or negedge nrst) begin
        for (int l = 0; l < LANES; l++) begin
            mag = 256 * (meas[l].input_idx + 1);
            if (!nrst) begin
                adc[l] <= '0;
                cnt[l] <= 0;
            end else begin
                adc[l].done <= 1'b0;
                // Data toggles between readings so a stale value never looks fresh
                adc[l].data <= ~adc[l].data;
                cnt[l] <= (cnt[l] > 0) ? cnt[l] - 1 : 0;
                if (meas[l].start) begin
                    cnt[l] <= (l % 2 == 1) ? 12 : 2;
                end else if (cnt[l] == 1) begin
                    adc[l].done <= 1'b1;
                    adc[l].over <= over[l];
                    adc[l].data <= DATA_W'(meas[l].negative ? 32 - mag : 32 + mag);
                end
            end
        end
    end
endmodule : adc_front_end_model

// ==== dv/sensor_input_scan_controller_properties.sv ====
`timescale 1ns/10ps
module scan_checker
    import sensor_scan_pkg::*;
#(
    parameter int SLOT_CYCLES = 20
) (
    input wire logic                        clk,
    input wire logic                        nrst,
    input wire logic                        ce,
    input wire cmd_t                        cmd,
    input wire adc_res_t   [LANES-1:0]      adc,
    input wire meas_req_t  [LANES-1:0]      meas,
    input wire rdg_t       [LANES-1:0]      rdg,
    input wire input_cfg_t [NUM_INPUTS-1:0] cfg_status
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic       take;
    logic [7:0] gap;
    assign take = ce && cmd.valid && cmd.idx <= IDX_LAST;
    // Lane B stays a diode, so its slot never stretches
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) gap <= 8'h00;
        else if (meas[1].start) gap <= 8'h01;
        else if (gap != 8'h00 && gap != 8'hff) gap <= gap + 8'h01;
    end
    property p_diode_low;
        take && cmd.op == input_type_command && cmd.value == 4'h1
            |=> !cfg_status[$past(cmd.idx)].diode_high_current;
    endproperty
    a_diode_low: assert property (p_diode_low) else $error("diode current left high");
    property p_res_dflt;
        take && cmd.op == input_type_command && cmd.value inside {4'h2, 4'h3}
            |=> cfg_status[$past(cmd.idx)].autorange && cfg_status[$past(cmd.idx)].reversal;
    endproperty
    a_res_dflt: assert property (p_res_dflt) else $error("resistor defaults missing");
    property p_diode_rng;
        take && cmd.op == range_command && cfg_status[cmd.idx].stype == type_diode
            && cmd.value > RANGE_DIODE_TOP
            |=> cfg_status[$past(cmd.idx)].range == $past(cfg_status[cmd.idx].range);
    endproperty
    a_diode_rng: assert property (p_diode_rng) else $error("bad diode range taken");
    property p_ptc_exc;
        meas[0].start && cfg_status[0].stype == positive_coefficient_resistor
            |-> meas[0].exc == exc_1ma;
    endproperty
    a_ptc_exc: assert property (p_ptc_exc) else $error("ptc current wrong");
    property p_ntc_exc;
        meas[0].start && cfg_status[0].stype == negative_coefficient_resistor
            |-> meas[0].exc == exc_t'(meas[0].range + EXC_NTC_BASE);
    endproperty
    a_ntc_exc: assert property (p_ntc_exc) else $error("ntc current wrong");
    property p_no_auto;
        cfg_status[1].stype == type_diode |-> !cfg_status[1].autorange;
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("autorange on diode");
    property p_polarity;
        meas[0].start && !cfg_status[0].reversal |-> !meas[0].negative;
    endproperty
    a_polarity: assert property (p_polarity) else $error("reversed without reversal");
    property p_slot;
        meas[1].start && gap != 8'h00 |-> gap == SLOT_CYCLES + 1;
    endproperty
    a_slot: assert property (p_slot) else $error("slot length wrong");
    property p_report;
        adc[1].done |=> rdg[1].valid && rdg[1].value == $past(adc[1].data);
    endproperty
    a_report: assert property (p_report) else $error("reading not reported");
    c_long: cover property (meas[0].start && meas[0].exc == exc_100na);
    c_pair: cover property (rdg[0].valid && meas[0].negative);
    c_wrap: cover property (meas[2].start && meas[2].input_idx == IDX_C1);
endmodule : scan_checker
bind sensor_input_scan_controller scan_checker #(.SLOT_CYCLES(SLOT_CYCLES)) chk (
    .clk(clk), .nrst(nrst), .ce(ce), .cmd(cmd), .adc(adc),
    .meas(meas), .rdg(rdg), .cfg_status(cfg_status));

// ==== dv/sensor_input_scan_controller_test.sv ====
`timescale 1ns/10ps
module sensor_input_scan_controller_test
    import sensor_scan_pkg::*;
();
    localparam int SLOT = 20;
    typedef struct packed {
        logic [3:0] idx;
        cmd_op_t    op;
        logic [3:0] val;
        input_cfg_t exp;
    } row_t;
    row_t rows [11] = '{'{4'h0, input_type_command, 4'h2, 9'h103},
        '{4'h0, range_command, 4'h3, 9'h103}, '{4'h0, autorange_command, 4'h0, 9'h101},
        '{4'h0, range_command, 4'h6, 9'h119}, '{4'h0, range_command, 4'h7, 9'h119},
        '{4'h0, reversal_command, 4'h0, 9'h118}, '{4'h1, diode_current_command, 4'h1, 9'h0c0},
        '{4'h1, input_type_command, 4'h1, 9'h080}, '{4'h1, range_command, 4'h1, 9'h084},
        '{4'h1, range_command, 4'h2, 9'h084}, '{4'h1, autorange_command, 4'h1, 9'h084}};
    logic [3:0] order [4] = '{4'h3, 4'h4, 4'h6, 4'h2};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    cmd_t cmd = '0;
    logic [LANES-1:0] over = '0;
    adc_res_t [LANES-1:0] adc;
    meas_req_t [LANES-1:0] meas;
    rdg_t [LANES-1:0] rdg;
    input_cfg_t [NUM_INPUTS-1:0] cfg_status;
    int num_errors = 0;
    int total_checks = 0;
    int k;
    int n;
    logic p;
    always #5 clk = ~clk;
    sensor_input_scan_controller #(.SLOT_CYCLES(SLOT)) DUT (.clk(clk), .nrst(nrst), .ce(ce),
        .cmd(cmd), .adc(adc), .meas(meas), .rdg(rdg), .cfg_status(cfg_status));
    adc_front_end_model model (.clk(clk), .nrst(nrst), .meas(meas), .over(over), .adc(adc));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Idle edge first, so valid never falls and rises in one time step
    task automatic do_cmd(input logic [3:0] i, input cmd_op_t o, input logic [3:0] v);
        @(posedge clk);
        #1 cmd = '{1'b1, i, o, v};
        @(posedge clk);
        #1 cmd.valid = 1'b0;
    endtask : do_cmd
    task automatic wait_ev(input int l, input bit rd);
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while ((rd ? rdg[l].valid : meas[l].start) !== 1'b1 && k < 200);
        if (k == 200) num_errors++;
    endtask : wait_ev
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        #100000 num_errors++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 nrst = 1'b1;
        for (int i = 0; i < NUM_INPUTS; i++)
            check(cfg_status[i], {(i inside {0, 1, 2, 7}) ? type_diode : type_disabled, 7'h00});
        foreach (rows[r]) begin
            do_cmd(rows[r].idx, rows[r].op, rows[r].val);
            check(cfg_status[rows[r].idx], rows[r].exp);
        end
        do_cmd(4'h0, input_type_command, 4'h2);
        over[0] = 1'b1;
        for (n = 0; n < 12 && cfg_status[0].range !== RANGE_PTC_TOP; n++) wait_ev(0, 0);
        check(meas[0].exc, exc_1ma);
        over[0] = 1'b0;
        do_cmd(4'h0, input_type_command, 4'h3);
        check(cfg_status[0], {negative_coefficient_resistor, 7'h03});
        over[0] = 1'b1;
        for (n = 0; n < 12 && cfg_status[0].range !== RANGE_NTC_TOP; n++) wait_ev(0, 0);
        over[0] = 1'b0;
        check(cfg_status[0].range, RANGE_NTC_TOP);
        check(meas[0].exc, exc_100na);
        check(meas[0].negative, 1'b0);
        wait_ev(0, 0);
        wait_ev(0, 0);
        check(k, 2 * SLOT + 1);
        p = meas[0].negative;
        wait_ev(0, 0);
        check(meas[0].negative, !p);
        wait_ev(0, 1);
        check(rdg[0].value, 32'h100);
        do_cmd(4'h0, reversal_command, 4'h0);
        wait_ev(0, 0);
        wait_ev(0, 0);
        check(k, SLOT + 1);
        wait_ev(0, 1);
        check(rdg[0].value, 32'h120);
        do_cmd(4'h3, input_type_command, 4'h3);
        do_cmd(4'h4, input_type_command, 4'h2);
        do_cmd(4'h6, input_type_command, 4'h1);
        check(cfg_status[4].stype, positive_coefficient_resistor);
        for (n = 0; n < 8 && meas[2].input_idx !== IDX_C1; n++) wait_ev(2, 0);
        foreach (order[j]) begin
            wait_ev(2, 0);
            check(meas[2].input_idx, order[j]);
        end
        wait_ev(3, 0);
        wait_ev(3, 0);
        check(k, SLOT + 1);
        print_verdict();
    end
endmodule : sensor_input_scan_controller_test
